/* verilog/alert_routing_defs.svh */
// register map, reset values, field positions and timing counts of the alert router
`ifndef ALERT_ROUTING_DEFS_SVH
`define ALERT_ROUTING_DEFS_SVH

// ==========================================================================
// register offsets
`define ADDR_ROUTING 8'h28
`define ADDR_FULLNESS 8'h29
`define ADDR_OC_BASE 8'h30
`define ADDR_UC_BASE 8'h34
`define ADDR_STATUS 8'h60
`define ADDR_MASK 8'h61

// ==========================================================================
// reset values
`define RST_ROUTING 24'h000000
`define RST_FULLNESS 16'h5540
`define RST_LIMIT 16'h0000

// ==========================================================================
// field positions in the routing register (channel 1 at the top bit)
`define RT_OC_TOP 23
`define RT_UC_TOP 19
`define RT_OV_TOP 15
`define RT_UV_TOP 11
`define RT_OP_TOP 7
`define RT_ACC_FULL 3
`define RT_CNT_FULL 2
`define RT_CONV_PULSE 1

// fullness field positions, channel 1 at bits 15-14
`define FL_CH1_LSB 14
`define FL_CNT_LSB 6
`define FL_IMPL_MASK 16'hFFC0

// ==========================================================================
// timing
`define CLK_PERIOD_NS 50
`define PULSE_TIME_NS 5000
`define PULSE_CYCLES ((`PULSE_TIME_NS) / (`CLK_PERIOD_NS))

`endif

/* verilog/alert_routing_pkg.sv */
// types shared by the alert router and its pulse timer
`default_nettype none

package alert_routing_pkg;

	// ======================================================================
	// fullness threshold codes
	typedef enum logic [1:0]
	{
		FILL_FULL = 2'h0,
		FILL_15_16 = 2'h1,
		FILL_7_8 = 2'h2,
		FILL_3_4 = 2'h3
	} fill_code_e;

	// ======================================================================
	// pulse timer states, one-hot
	typedef enum logic [1:0]
	{
		PULSE_IDLE = 2'h1,
		PULSE_HIGH = 2'h2
	} pulse_state_e;

endpackage : alert_routing_pkg

`default_nettype wire

/* verilog/pulse_timer.sv */
// fixed-length pulse generator for the conversion-done mark
`default_nettype none
`include "alert_routing_defs.svh"

module pulse_timer
	import alert_routing_pkg::*;
#(
	parameter int CYCLES = `PULSE_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// trigger and pulse
	input wire logic start_i,
	output logic busy_o
);

	// ======================================================================
	// state and down counter
	pulse_state_e state;
	pulse_state_e next_state;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	wire logic cnt_zero = (cnt == 16'h0000);

	// a start during a pulse is ignored, so the pulse width never stretches
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			PULSE_IDLE:
			begin
				if (start_i)
				begin
					next_state = PULSE_HIGH;
					next_cnt = 16'(CYCLES - 1);
				end
			end
			PULSE_HIGH:
			begin
				if (cnt_zero)
					next_state = PULSE_IDLE;
				else
					next_cnt = cnt - 16'h0001;
			end
			default:
				next_state = PULSE_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			state <= PULSE_IDLE;
			cnt <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// output taken from the state flop
	assign busy_o = (state == PULSE_HIGH);

	// ======================================================================
	// checks: high length counted in helper logic
	logic [15:0] high_len;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			high_len <= 16'h0000;
		else if (busy_o)
			high_len <= high_len + 16'h0001;
		else
			high_len <= 16'h0000;
	end

	pulse_width_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$fell(busy_o) |-> high_len == 16'(CYCLES))
		else $error("conversion pulse width wrong");
	pulse_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(start_i && !busy_o) |=> busy_o)
		else $error("pulse did not start");

endmodule : pulse_timer

`default_nettype wire

/* verilog/alert_routing.sv */
// alert threshold, limit and routing logic for the second alert pin
`default_nettype none
`include "alert_routing_defs.svh"

// How it works
// - channel overpower routes at bits 7 to 4
// - bit 3 routes accumulator fullness alert
// - bit 2 routes sample count fullness
// - bit 1 gives 5 us end pulse
// - pulse drives pin only in alert mode
// - two-bit accumulator thresholds, reset fifteen sixteenths
// - count threshold bits 7-6, same codes
// - trip when content reaches selected fraction
// - threshold bits 5-0 read zero
// - signed overcurrent limits, reset zero
// - overcurrent limits at 0x30 to 0x33
// - signed undercurrent limits, reset zero
// - undercurrent limits at 0x34 to 0x37
// - master enable gates routing except the bit 1 pulse; alert mode gates the pin
// - current and voltage routes at bits 23-8
module alert_routing
	import alert_routing_pkg::*;
#(
	parameter int PULSE_LEN = `PULSE_CYCLES
)
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	// register port
	input wire logic [7:0] ADDR_I,
	input wire logic [23:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [23:0] RDATA_O,
	// conversion engine
	input wire logic CONV_DONE_I,
	input wire logic CUR_VALID_I,
	input wire logic [63:0] CUR_RESULT_I,
	input wire logic [3:0] OP_TRIP_I,
	input wire logic [3:0] OV_TRIP_I,
	input wire logic [3:0] UV_TRIP_I,
	// accumulator and sample count fullness: top four bits and overflow of each
	input wire logic [15:0] ACC_TOP_I,
	input wire logic [3:0] ACCUMULATOR_FULL_ROUTE_I,
	input wire logic [3:0] CNT_TOP_I,
	input wire logic CNT_OVF_I,
	// pin configuration
	input wire logic [23:0] MASTER_EN_I,
	input wire logic PIN_ALERT_MODE_I,
	input wire logic SLOW_PIN_I,
	// pin and interrupt
	output logic SECOND_ALERT_PIN_O,
	output logic SLOW_SAMPLE_O,
	output logic IRQ_O
);

	// ======================================================================
	// functions
	// true once the top nibble reaches the chosen fraction, or on overflow
	function automatic logic fill_hit(input logic [1:0] code, input logic [3:0] top,
		input logic ovf);
		logic hit;
		hit = ovf;
		case (fill_code_e'(code))
			FILL_FULL: hit = ovf;
			FILL_15_16: hit = ovf || (top >= 4'hF);
			FILL_7_8: hit = ovf || (top >= 4'hE);
			FILL_3_4: hit = ovf || (top >= 4'hC);
			default: hit = ovf;
		endcase
		return hit;
	endfunction : fill_hit

	// four consecutive offsets from a base
	function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base);
		return (addr[7:2] == base[7:2]);
	endfunction : in_bank

	// ======================================================================
	// registers
	logic [23:0] routing;
	logic [15:0] fullness;
	logic [15:0] overcurrent_limit [4];
	logic [15:0] undercurrent_limit [4];
	logic [10:0] status;
	logic [10:0] mask;
	logic [3:0] oc_hit;
	logic [3:0] uc_hit;

	// ======================================================================
	// address decode
	wire logic hit_routing = (ADDR_I == `ADDR_ROUTING);
	wire logic hit_fullness = (ADDR_I == `ADDR_FULLNESS);
	wire logic hit_oc = in_bank(ADDR_I, `ADDR_OC_BASE);
	wire logic hit_uc = in_bank(ADDR_I, `ADDR_UC_BASE);
	wire logic hit_status = (ADDR_I == `ADDR_STATUS);
	wire logic hit_mask = (ADDR_I == `ADDR_MASK);
	wire logic [1:0] bank_idx = ADDR_I[1:0];

	// ======================================================================
	// routing register write, bit 0 not implemented
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			routing <= `RST_ROUTING;
		else if (WR_I && hit_routing)
			routing <= {WDATA_I[23:1], 1'b0};
	end

	// fullness thresholds; low six bits never stored
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			fullness <= `RST_FULLNESS;
		else if (WR_I && hit_fullness)
			fullness <= WDATA_I[15:0] & `FL_IMPL_MASK;
	end

	// limit banks, one word per channel
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			for (int i = 0; i < 4; i++)
			begin
				overcurrent_limit[i] <= `RST_LIMIT;
				undercurrent_limit[i] <= `RST_LIMIT;
			end
		end
		else if (WR_I && hit_oc)
			overcurrent_limit[bank_idx] <= WDATA_I[15:0];
		else if (WR_I && hit_uc)
			undercurrent_limit[bank_idx] <= WDATA_I[15:0];
	end

	// mask register
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			mask <= 11'h000;
		else if (WR_I && hit_mask)
			mask <= WDATA_I[10:0];
	end

	// ======================================================================
	// signed compare on each new result
	logic [3:0] next_oc_hit;
	logic [3:0] next_uc_hit;
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			next_oc_hit[c] = $signed(CUR_RESULT_I[16*c +: 16]) > $signed(overcurrent_limit[c]);
			next_uc_hit[c] = $signed(CUR_RESULT_I[16*c +: 16]) < $signed(undercurrent_limit[c]);
		end
	end

	// results hold until the next sample replaces them
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			oc_hit <= 4'h0;
			uc_hit <= 4'h0;
		end
		else if (CUR_VALID_I)
		begin
			oc_hit <= next_oc_hit;
			uc_hit <= next_uc_hit;
		end
	end

	// ======================================================================
	// fullness trips
	logic [3:0] acc_trip;
	always_comb
	begin
		for (int c = 0; c < 4; c++)
			acc_trip[c] = fill_hit(fullness[`FL_CH1_LSB - 2*c +: 2], ACC_TOP_I[4*c +: 4],
				ACCUMULATOR_FULL_ROUTE_I[c]);
	end
	wire logic acc_full = |acc_trip;
	wire logic cnt_full = fill_hit(fullness[`FL_CNT_LSB +: 2], CNT_TOP_I, CNT_OVF_I);

	// ======================================================================
	// routing: channel 1 sits at the top bit of each nibble, so reverse
	wire logic [23:0] route_en = routing & MASTER_EN_I;
	wire logic [3:0] oc_rev = {oc_hit[0], oc_hit[1], oc_hit[2], oc_hit[3]};
	wire logic [3:0] uc_rev = {uc_hit[0], uc_hit[1], uc_hit[2], uc_hit[3]};
	wire logic [3:0] op_rev = {OP_TRIP_I[0], OP_TRIP_I[1], OP_TRIP_I[2], OP_TRIP_I[3]};
	wire logic [3:0] ov_rev = {OV_TRIP_I[0], OV_TRIP_I[1], OV_TRIP_I[2], OV_TRIP_I[3]};
	wire logic [3:0] uv_rev = {UV_TRIP_I[0], UV_TRIP_I[1], UV_TRIP_I[2], UV_TRIP_I[3]};
	wire logic routed_cur = |(route_en[`RT_OC_TOP -: 4] & oc_rev)
		| |(route_en[`RT_UC_TOP -: 4] & uc_rev);
	wire logic routed_volt = |(route_en[`RT_OV_TOP -: 4] & ov_rev)
		| |(route_en[`RT_UV_TOP -: 4] & uv_rev);
	wire logic routed_op = |(route_en[`RT_OP_TOP -: 4] & op_rev);
	wire logic routed_acc = route_en[`RT_ACC_FULL] & acc_full;
	wire logic routed_cnt = route_en[`RT_CNT_FULL] & cnt_full;
	wire logic routed_any = routed_cur | routed_volt | routed_op | routed_acc | routed_cnt;

	// ======================================================================
	// conversion-done pulse
	wire logic pulse_start = CONV_DONE_I & routing[`RT_CONV_PULSE];
	logic pulse_busy;

	pulse_timer #(
		.CYCLES(PULSE_LEN)
	) u_pulse (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.start_i(pulse_start),
		.busy_o(pulse_busy)
	);

	// pin only carries alerts in alert mode; the slow input is lost then
	wire logic next_pin = PIN_ALERT_MODE_I & (routed_any | pulse_busy);
	wire logic next_slow = ~PIN_ALERT_MODE_I & SLOW_PIN_I;

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			SECOND_ALERT_PIN_O <= 1'b0;
			SLOW_SAMPLE_O <= 1'b0;
		end
		else
		begin
			SECOND_ALERT_PIN_O <= next_pin;
			SLOW_SAMPLE_O <= next_slow;
		end
	end

	// ======================================================================
	// interrupt status: uc 10-7, oc 6-3, acc 2, cnt 1, conv 0
	wire logic [10:0] events = {uc_hit, oc_hit, acc_full, cnt_full, CONV_DONE_I};
	wire logic [10:0] clr_bits = (WR_I && hit_status) ? WDATA_I[10:0] : 11'h000;

	// set wins over clear so a same-cycle event is never dropped
	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
		begin
			status <= 11'h000;
			IRQ_O <= 1'b0;
		end
		else
		begin
			status <= (status & ~clr_bits) | events;
			IRQ_O <= |(((status & ~clr_bits) | events) & mask);
		end
	end

	// ======================================================================
	// read mux, answer one cycle after the strobe
	logic [23:0] rd_mux;
	always_comb
	begin
		rd_mux = 24'h000000;
		if (hit_routing)
			rd_mux = routing;
		else if (hit_fullness)
			rd_mux = {8'h00, fullness};
		else if (hit_oc)
			rd_mux = {8'h00, overcurrent_limit[bank_idx]};
		else if (hit_uc)
			rd_mux = {8'h00, undercurrent_limit[bank_idx]};
		else if (hit_status)
			rd_mux = {13'h0, status};
		else if (hit_mask)
			rd_mux = {13'h0, mask};
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RESET_N_I)
			RDATA_O <= 24'h000000;
		else if (RD_I)
			RDATA_O <= rd_mux;
		else
			RDATA_O <= 24'h000000;
	end

	// ======================================================================
	// checks
	pin_mode_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		!PIN_ALERT_MODE_I |=> !SECOND_ALERT_PIN_O)
		else $error("pin driven outside alert mode");
	op_route_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(PIN_ALERT_MODE_I && OP_TRIP_I[0] && routing[7] && MASTER_EN_I[7])
		|=> SECOND_ALERT_PIN_O)
		else $error("channel 1 overpower not routed");
	acc_route_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(PIN_ALERT_MODE_I && acc_full && route_en[3]) |=> SECOND_ALERT_PIN_O)
		else $error("accumulator fullness not routed");
	cnt_route_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(PIN_ALERT_MODE_I && cnt_full && route_en[2]) |=> SECOND_ALERT_PIN_O)
		else $error("count fullness not routed");
	conv_pulse_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(CONV_DONE_I && routing[1] && !pulse_busy && PIN_ALERT_MODE_I) ##1 PIN_ALERT_MODE_I
		|=> SECOND_ALERT_PIN_O)
		else $error("conversion pulse missing on pin");
	thr_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(RD_I && hit_fullness) |=> RDATA_O[5:0] == 6'h00)
		else $error("unimplemented threshold bits read nonzero");
	acc_fill_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(fullness[15:14] == 2'h3 && ACC_TOP_I[3:0] >= 4'hC) |-> acc_full)
		else $error("three-quarter threshold missed");
	oc_cmp_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CUR_VALID_I |=> oc_hit[0] == ($signed($past(CUR_RESULT_I[15:0]))
		> $signed($past(overcurrent_limit[0]))))
		else $error("overcurrent compare wrong");
	uc_wr_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(WR_I && ADDR_I == 8'h37) |=> undercurrent_limit[3] == $past(WDATA_I[15:0]))
		else $error("undercurrent channel 4 write lost");
	master_gate_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(MASTER_EN_I == 24'h000000 && !pulse_busy) |=> !SECOND_ALERT_PIN_O)
		else $error("alert routed without master enable");
	uc_cmp_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CUR_VALID_I |=> uc_hit[0] == ($signed($past(CUR_RESULT_I[15:0]))
		< $signed($past(undercurrent_limit[0]))))
		else $error("undercurrent compare wrong");
	oc_wr_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(WR_I && ADDR_I == 8'h30) |=> overcurrent_limit[0] == $past(WDATA_I[15:0]))
		else $error("overcurrent channel 1 write lost");
	slow_block_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		PIN_ALERT_MODE_I |=> !SLOW_SAMPLE_O)
		else $error("slow request passed in alert mode");
	op_route4_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		(PIN_ALERT_MODE_I && OP_TRIP_I[3] && route_en[4]) |=> SECOND_ALERT_PIN_O)
		else $error("channel 4 overpower not routed");

	conv_pulse_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		pulse_start ##2 SECOND_ALERT_PIN_O);
	oc_alert_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I)
		routed_cur ##1 SECOND_ALERT_PIN_O);
	irq_c: cover property (@(posedge CLK_I) disable iff (!RESET_N_I) $rose(IRQ_O));

endmodule : alert_routing

`default_nettype wire

/* verification/alert_host.sv */
// host-side watcher that measures pulses on the second alert pin
`default_nettype none

module alert_host
(
	// clock
	input wire logic clk_i,
	// pin under watch
	input wire logic pin_i,
	// measurements
	output var int rises_o,
	output var int width_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int run = 0;

	// ======================================================================
	// width of the last finished high period, in clocks
	// counted on fall so a pulse still running is never reported short
	always @(posedge clk_i)
	begin
		if (pin_i === 1'b1)
			run <= run + 1;
		else if (run != 0)
		begin
			width_o <= run;
			rises_o <= rises_o + 1;
			run <= 0;
		end
	end
endmodule : alert_host

`default_nettype wire

/* verification/alert_routing_bench.sv */
// bench for the alert router: registers, routing, pulse and interrupt
`default_nettype none

module alert_routing_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int PLEN = 4;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, conv = 0, cv = 0, mode = 1, slow = 0, covf = 0;
	logic [7:0] addr = 8'h00;
	logic [23:0] wdata = 24'h000000, men = 24'hFFFFFF;
	logic [63:0] cur = 64'h0;
	logic [3:0] op = 4'h0, ov = 4'h0, uv = 4'h0, aovf = 4'h0, ctop = 4'h0;
	logic [15:0] atop = 16'h0000;
	logic [23:0] rdata;
	logic pin, slow_o, irq;
	int errors = 0, cmp_count = 0, rises, width, r0;

	alert_routing #(.PULSE_LEN(PLEN)) DUT (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CONV_DONE_I(conv),
		.CUR_VALID_I(cv), .CUR_RESULT_I(cur), .OP_TRIP_I(op), .OV_TRIP_I(ov), .UV_TRIP_I(uv),
		.ACC_TOP_I(atop), .ACCUMULATOR_FULL_ROUTE_I(aovf), .CNT_TOP_I(ctop), .CNT_OVF_I(covf),
		.MASTER_EN_I(men), .PIN_ALERT_MODE_I(mode), .SLOW_PIN_I(slow),
		.SECOND_ALERT_PIN_O(pin), .SLOW_SAMPLE_O(slow_o), .IRQ_O(irq));

	alert_host host (.clk_i(clk), .pin_i(pin), .rises_o(rises), .width_o(width));

	// ======================================================================
	// 20 MHz clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	task end_sim;
	begin
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask : chk

	// one-cycle write and read strobes, read data checked in the next cycle
	task wr_reg(input logic [7:0] a, input logic [23:0] d);
	begin
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, input logic [23:0] exp);
	begin
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	end
	endtask : rd_reg

	// let level trips settle through the registered pin
	task pin_is(input logic exp);
	begin
		repeat (3) @(posedge clk);
		#1 chk(pin, exp);
	end
	endtask : pin_is

	task sample(input logic [15:0] v);
	begin
		@(posedge clk);
		cur <= {48'h0, v};
		cv <= 1'b1;
		@(posedge clk);
		cv <= 1'b0;
	end
	endtask : sample

	task conv_pulse;
	begin
		@(posedge clk);
		conv <= 1'b1;
		@(posedge clk);
		conv <= 1'b0;
		repeat (PLEN + 8) @(posedge clk);
	end
	endtask : conv_pulse

	// ======================================================================
	// watchdog well beyond the expected few hundred cycles
	initial
	begin
		#400000;
		errors++;
		end_sim();
	end

	// ======================================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and access kinds
		rd_reg(8'h29, 24'h005540);
		rd_reg(8'h28, 24'h000000);
		for (int i = 0; i < 8; i++)
			rd_reg(8'h30 + i, 24'h000000);
		wr_reg(8'h29, 24'hFFFFFF);
		rd_reg(8'h29, 24'h00FFC0);
		wr_reg(8'h28, 24'hFFFFFF);
		rd_reg(8'h28, 24'hFFFFFE);
		rd_reg(8'h38, 24'h000000);
		men <= 24'h000000;
		for (int i = 0; i < 8; i++)
			wr_reg(8'h30 + i, 24'h008000 | (i * 24'h111));
		for (int i = 0; i < 8; i++)
			rd_reg(8'h30 + i, 24'h008000 | (i * 24'h111));
		wr_reg(8'h29, 24'h005540);
		wr_reg(8'h28, 24'h000000);
		men <= 24'hFFFFFF;
		// overpower route per channel, channel 1 at bit 7
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(8'h28, 24'h80 >> c);
			op <= 4'h1 << c;
			pin_is(1'b1);
			op <= 4'h1 << ((c + 1) % 4);
			pin_is(1'b0);
		end
		op <= 4'h0;
		// accumulator fullness thresholds
		wr_reg(8'h28, 24'h000008);
		atop <= 16'h000E;
		pin_is(1'b0);
		atop <= 16'h000F;
		pin_is(1'b1);
		wr_reg(8'h29, 24'h00D540);
		atop <= 16'h000C;
		pin_is(1'b1);
		atop <= 16'h000B;
		pin_is(1'b0);
		wr_reg(8'h29, 24'h001540);
		atop <= 16'h000F;
		pin_is(1'b0);
		aovf <= 4'h1;
		pin_is(1'b1);
		men <= 24'h000000;
		pin_is(1'b0);
		men <= 24'hFFFFFF;
		aovf <= 4'h0;
		atop <= 16'h0000;
		// sample count fullness
		wr_reg(8'h28, 24'h000004);
		ctop <= 4'hE;
		pin_is(1'b0);
		ctop <= 4'hF;
		pin_is(1'b1);
		ctop <= 4'h0;
		// voltage routes: channel 4 overvoltage at bit 12, channel 1 undervoltage at bit 11
		wr_reg(8'h28, 24'h001000);
		ov <= 4'h8;
		pin_is(1'b1);
		ov <= 4'h0;
		wr_reg(8'h28, 24'h000800);
		uv <= 4'h8;
		pin_is(1'b0);
		uv <= 4'h1;
		pin_is(1'b1);
		uv <= 4'h0;
		// signed current limits on channel 1
		men <= 24'h000000;
		wr_reg(8'h30, 24'h000010);
		wr_reg(8'h34, 24'h00FFFB);
		men <= 24'hFFFFFF;
		wr_reg(8'h28, 24'h800000);
		sample(16'h0011);
		pin_is(1'b1);
		sample(16'h0010);
		pin_is(1'b0);
		wr_reg(8'h28, 24'h080000);
		sample(16'hFFFA);
		pin_is(1'b1);
		sample(16'h0001);
		pin_is(1'b0);
		// conversion-done pulse and interrupt
		wr_reg(8'h28, 24'h000002);
		wr_reg(8'h60, 24'h0007FF);
		wr_reg(8'h61, 24'h000001);
		r0 = rises;
		conv_pulse();
		chk(rises, r0 + 1);
		chk(width, PLEN);
		// channels 2-4 read zero against negative overcurrent limits, so oc bits 6-4 stay set
		rd_reg(8'h60, 24'h000071);
		chk(irq, 1'b1);
		wr_reg(8'h60, 24'h000001);
		#1 chk(irq, 1'b0);
		// pin in slow mode: no pulse, slow request passes
		mode <= 1'b0;
		slow <= 1'b1;
		conv_pulse();
		chk(rises, r0 + 1);
		chk(slow_o, 1'b1);
		mode <= 1'b1;
		pin_is(1'b0);
		chk(slow_o, 1'b0);
		wr_reg(8'h28, 24'h000000);
		conv_pulse();
		chk(rises, r0 + 1);
		end_sim();
	end
endmodule : alert_routing_bench

`default_nettype wire
